// file: hdl/adc_conversion_control.sv
// Conversion control of a 12-bit successive-approximation converter with an AXI4-Lite slave
//
// Contract
// - Start high then low launches a conversion
// - Start held high resets converter, busy high
// - Hardware clears busy when conversion finishes
// - Completion sets request flag, interrupt when enabled
// - Divider select gives divide by 1 to 64
// - Converter powered only while power-off bit zero
// - Reference select takes reference pin, disables sharing
// - Pin enable makes pin converter input only
// - Pull-high disconnected on converter input pins
// - Pin enable overrides port direction setting
// - Conversion takes sixteen converter clock periods
// - Result is 12-bit code, step reference/4096
// - Channel codes 0 to 11 route inputs
// - Internal-reference select routes bandgap, drops channels
// - Format bit selects left or right alignment
//
// Our own choices: the AXI4-Lite interface to the registers and the register offsets.
`include "adc_ctrl_map.svh"

module adc_conversion_control (
    input  wire logic                     clk_sys,
    input  wire logic                     sys_rst,
    input  wire logic [7:0]               s_axi_awaddr,
    input  wire logic                     s_axi_awvalid,
    output logic                          s_axi_awready,
    input  wire logic [31:0]              s_axi_wdata,
    input  wire logic [3:0]               s_axi_wstrb,
    input  wire logic                     s_axi_wvalid,
    output logic                          s_axi_wready,
    output logic [1:0]                    s_axi_bresp,
    output logic                          s_axi_bvalid,
    input  wire logic                     s_axi_bready,
    input  wire logic [7:0]               s_axi_araddr,
    input  wire logic                     s_axi_arvalid,
    output logic                          s_axi_arready,
    output logic [31:0]                   s_axi_rdata,
    output logic [1:0]                    s_axi_rresp,
    output logic                          s_axi_rvalid,
    input  wire logic                     s_axi_rready,
    input  wire logic [11:0]              port_dir_input,
    input  wire logic [11:0]              pullup_request,
    input  wire logic                     comparator_in,
    output logic [11:0]                   sar_trial_code,
    output logic                          conv_sample,
    output logic                          conv_reset,
    output adc_ctrl_pkg::pin_ctrl_t       pin_ctrl,
    output logic                          conv_irq
);
    import adc_ctrl_pkg::*;

    adc_state_t  q;
    adc_state_t  d;
    logic        tick;
    logic [5:0]  div_mask;
    logic        do_write;
    logic        do_read;
    logic [3:0]  bit_idx;
    logic [7:0]  res_hi;
    logic [7:0]  res_lo;
    logic [7:0]  wbyte;

    ////////////////////////////////////////////////////////////////////////////
    // Converter clock enable and result formatting

    always_comb begin
        // Undefined code 111 is run as the slowest rate rather than stopping
        if (q.conv_clk_div_sel == `ADC_DIV_UNDEF) begin
            div_mask = 6'h3f;
        end else begin
            div_mask = 6'((7'h01 << q.conv_clk_div_sel) - 7'h01);
        end
    end

    assign tick    = ((q.div_cnt & div_mask) == div_mask) && !q.conv_power_off;
    assign bit_idx = 4'(`ADC_SAR_BITS - 4'h1 - q.tick_cnt[3:0]);

    always_comb begin
        if (q.result_align_sel) begin
            res_hi = {4'h0, q.result[11:8]};
            res_lo = q.result[7:0];
        end else begin
            res_hi = q.result[11:4];
            res_lo = {q.result[3:0], 4'h0};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Next state

    assign do_write = q.aw_held && q.w_held && !q.bvalid;
    assign do_read  = s_axi_arvalid && !q.rvalid;
    assign wbyte    = q.w_data[7:0];

    always_comb begin
        d = q;
        d.cmp_meta = comparator_in;
        d.cmp_sync = q.cmp_meta;

        // Write channel: address and data taken in either order
        if (s_axi_awvalid && !q.aw_held) begin
            d.aw_held = 1'b1;
            d.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !q.w_held) begin
            d.w_held = 1'b1;
            d.w_data = s_axi_wdata;
            d.w_strb = s_axi_wstrb;
        end
        if (q.bvalid && s_axi_bready) begin
            d.bvalid = 1'b0;
        end
        if (do_write) begin
            d.aw_held = 1'b0;
            d.w_held  = 1'b0;
            d.bvalid  = 1'b1;
            d.bresp   = 2'h0;
            if (q.w_strb[0]) begin
                unique case (q.aw_addr)
                    `ADC_OFS_CTRL_A: begin
                        d.start            = wbyte[`ADC_A_START];
                        d.conv_power_off   = wbyte[`ADC_A_PWR_OFF];
                        d.result_align_sel = wbyte[`ADC_A_ALIGN];
                        d.channel_sel      = wbyte[3:0];
                    end
                    `ADC_OFS_CTRL_B: begin
                        d.internal_ref_input_sel = wbyte[`ADC_B_INT_REF];
                        d.bandgap_en             = wbyte[`ADC_B_BANDGAP];
                        d.ref_source_sel         = wbyte[`ADC_B_REF_SRC];
                        d.conv_clk_div_sel       = wbyte[2:0];
                    end
                    `ADC_OFS_PIN_LO: d.analog_pin_enables[7:0]  = wbyte;
                    `ADC_OFS_PIN_HI: d.analog_pin_enables[11:8] = wbyte[3:0];
                    `ADC_OFS_IRQ: begin
                        d.conv_irq_enable   = wbyte[`ADC_IRQ_ENABLE];
                        d.global_irq_enable = wbyte[`ADC_IRQ_GLOBAL];
                        // Request flag may only be cleared by software
                        if (!wbyte[`ADC_IRQ_FLAG]) begin
                            d.conv_irq_flag = 1'b0;
                        end
                    end
                    `ADC_OFS_RES_LO, `ADC_OFS_RES_HI: begin
                    end
                    default: d.bresp = 2'h2;
                endcase
            end else if (q.aw_addr > `ADC_OFS_IRQ || q.aw_addr[1:0] != 2'h0) begin
                d.bresp = 2'h2;
            end
        end

        // Read channel
        if (q.rvalid && s_axi_rready) begin
            d.rvalid = 1'b0;
        end
        if (do_read) begin
            d.rvalid = 1'b1;
            d.rresp  = 2'h0;
            d.rdata  = 32'h0;
            unique case (s_axi_araddr)
                `ADC_OFS_CTRL_A: d.rdata[7:0] = {q.start, q.conv_busy_flag, q.conv_power_off,
                                                 q.result_align_sel, q.channel_sel};
                `ADC_OFS_CTRL_B: d.rdata[7:0] = {q.internal_ref_input_sel, q.bandgap_en, 1'b0,
                                                 q.ref_source_sel, 1'b0, q.conv_clk_div_sel};
                `ADC_OFS_PIN_LO: d.rdata[7:0] = q.analog_pin_enables[7:0];
                `ADC_OFS_PIN_HI: d.rdata[7:0] = {4'h0, q.analog_pin_enables[11:8]};
                `ADC_OFS_RES_LO: d.rdata[7:0] = res_lo;
                `ADC_OFS_RES_HI: d.rdata[7:0] = res_hi;
                `ADC_OFS_IRQ:    d.rdata[7:0] = {5'h0, q.conv_irq_flag, q.global_irq_enable,
                                                 q.conv_irq_enable};
                default:         d.rresp = 2'h2;
            endcase
        end

        // Converter clock divider runs free in the idle and run states; the held state clears it
        d.div_cnt = 6'(q.div_cnt + 6'h01);

        unique case (q.conv_state)
            CONV_IDLE: begin
                if (q.start) begin
                    d.conv_state     = CONV_HELD;
                    d.conv_busy_flag = 1'b1;
                end
            end
            CONV_HELD: begin
                d.div_cnt  = 6'h00;
                d.tick_cnt = 5'h00;
                d.sar      = 12'h800;
                if (!q.start) begin
                    d.conv_state = CONV_RUN;
                end
            end
            CONV_RUN: begin
                if (q.start) begin
                    // A fresh rising step aborts and re-arms the converter
                    d.conv_state = CONV_HELD;
                end else if (tick) begin
                    d.tick_cnt = 5'(q.tick_cnt + 5'h01);
                    if (q.tick_cnt < 5'(`ADC_SAR_BITS)) begin
                        // Keep the trial bit only if the input is above the trial level
                        if (!q.cmp_sync) begin
                            d.sar[bit_idx] = 1'b0;
                        end
                        if (bit_idx != 4'h0) begin
                            d.sar[4'(bit_idx - 4'h1)] = 1'b1;
                        end
                    end
                    if (d.tick_cnt == `ADC_CONV_TICKS) begin
                        d.conv_state     = CONV_IDLE;
                        d.result         = q.sar;
                        d.conv_busy_flag = 1'b0;
                        d.conv_irq_flag  = 1'b1;
                    end
                end
            end
        endcase

        // A start write landing with the clear cannot happen here, but set always wins
        if (q.start && !d.start && q.conv_state == CONV_IDLE) begin
            d.conv_busy_flag = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            q                    <= '0;
            q.conv_state         <= CONV_IDLE;
            q.conv_power_off     <= `ADC_RST_PWR_OFF;
            q.analog_pin_enables <= `ADC_RST_PIN_EN;
            // Busy reads low after reset because no conversion is pending
            q.sar                <= 12'h800;
        end else begin
            q <= d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign s_axi_awready = !q.aw_held;
    assign s_axi_wready  = !q.w_held;
    assign s_axi_bvalid  = q.bvalid;
    assign s_axi_bresp   = q.bresp;
    assign s_axi_arready = !q.rvalid;
    assign s_axi_rvalid  = q.rvalid;
    assign s_axi_rdata   = q.rdata;
    assign s_axi_rresp   = q.rresp;

    assign sar_trial_code = q.sar;
    assign conv_sample    = q.conv_state == CONV_RUN && q.tick_cnt == 5'h00;
    assign conv_reset     = q.conv_state == CONV_HELD || q.conv_power_off;

    assign conv_irq = q.conv_irq_flag && q.conv_irq_enable && q.global_irq_enable;

    always_comb begin
        pin_ctrl.analog_pin_enables = q.analog_pin_enables;
        pin_ctrl.pin_dir_input      = port_dir_input | q.analog_pin_enables;
        pin_ctrl.pin_pullup_on      = pullup_request & ~q.analog_pin_enables;
        pin_ctrl.vref_pin_takeover  = q.ref_source_sel;
        pin_ctrl.ref_source_sel     = q.ref_source_sel;
        pin_ctrl.conv_power_off     = q.conv_power_off;
        pin_ctrl.bandgap_route      = q.internal_ref_input_sel;
        pin_ctrl.channel_route      = q.channel_sel;
        pin_ctrl.channel_valid      = !q.internal_ref_input_sel
                                      && q.channel_sel <= `ADC_LAST_CHANNEL;
    end

endmodule

// file: hdl/adc_ctrl_map.svh
// Register offsets, field positions, reset values and timing counts of the converter control
`ifndef ADC_CTRL_MAP_SVH
`define ADC_CTRL_MAP_SVH

`define ADC_OFS_CTRL_A    8'h00
`define ADC_OFS_CTRL_B    8'h04
`define ADC_OFS_PIN_LO    8'h08
`define ADC_OFS_PIN_HI    8'h0c
`define ADC_OFS_RES_LO    8'h10
`define ADC_OFS_RES_HI    8'h14
`define ADC_OFS_IRQ       8'h18

`define ADC_A_START       7
`define ADC_A_BUSY        6
`define ADC_A_PWR_OFF     5
`define ADC_A_ALIGN       4
`define ADC_B_INT_REF     7
`define ADC_B_BANDGAP     6
`define ADC_B_REF_SRC     4
`define ADC_IRQ_ENABLE    0
`define ADC_IRQ_GLOBAL    1
`define ADC_IRQ_FLAG      2

`define ADC_RST_PWR_OFF   1'b1
`define ADC_RST_PIN_EN    12'hfff

`define ADC_CONV_TICKS    5'h10
`define ADC_SAR_BITS      4'hc
`define ADC_LAST_CHANNEL  4'hb
`define ADC_DIV_UNDEF     3'h7

`endif

// file: hdl/adc_ctrl_pkg.sv
// Types shared by the converter control block
package adc_ctrl_pkg;

    typedef enum logic [1:0] {
        CONV_IDLE,
        CONV_HELD,
        CONV_RUN
    } conv_state_t;

    typedef struct packed {
        logic [11:0] analog_pin_enables;
        logic [11:0] pin_dir_input;
        logic [11:0] pin_pullup_on;
        logic        vref_pin_takeover;
        logic        ref_source_sel;
        logic        conv_power_off;
        logic        bandgap_route;
        logic [3:0]  channel_route;
        logic        channel_valid;
    } pin_ctrl_t;

    typedef struct packed {
        conv_state_t conv_state;
        logic        start;
        logic        conv_busy_flag;
        logic        conv_power_off;
        logic        result_align_sel;
        logic [3:0]  channel_sel;
        logic        internal_ref_input_sel;
        logic        bandgap_en;
        logic        ref_source_sel;
        logic [2:0]  conv_clk_div_sel;
        logic [11:0] analog_pin_enables;
        logic        conv_irq_enable;
        logic        global_irq_enable;
        logic        conv_irq_flag;
        logic [5:0]  div_cnt;
        logic [4:0]  tick_cnt;
        logic [11:0] sar;
        logic [11:0] result;
        logic        cmp_meta;
        logic        cmp_sync;
        logic        aw_held;
        logic [7:0]  aw_addr;
        logic        w_held;
        logic [31:0] w_data;
        logic [3:0]  w_strb;
        logic        bvalid;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic [1:0]  bresp;
    } adc_state_t;

endpackage

// file: tb/adc_conversion_control_properties.sv
// Port checks for the converter control block
module adc_conversion_control_properties
    import adc_ctrl_pkg::*;
(
    input wire logic        clk_sys,
    input wire logic        sys_rst,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [11:0] port_dir_input,
    input wire logic [11:0] pullup_request,
    input wire logic        conv_sample,
    input wire logic        conv_reset,
    input wire pin_ctrl_t   pin_ctrl
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    ////////////////////////////////////////////////////////////////////////////////
    sequence b_wait;
        s_axi_bvalid && !s_axi_bready;
    endsequence
    sequence b_hold;
        s_axi_bvalid && $stable(s_axi_bresp);
    endsequence
    b_stands_a: assert property (b_wait |=> b_hold) else $error("write answer dropped");
    r_stands_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
        && $stable(s_axi_rdata)) else $error("read answer dropped");
    dir_override_a: assert property (pin_ctrl.pin_dir_input == (port_dir_input
        | pin_ctrl.analog_pin_enables)) else $error("pin direction wrong");
    pullup_drop_a: assert property (pin_ctrl.pin_pullup_on == (pullup_request
        & ~pin_ctrl.analog_pin_enables)) else $error("pull-high wrong");
    vref_take_a: assert property (pin_ctrl.vref_pin_takeover == pin_ctrl.ref_source_sel)
        else $error("reference pin wrong");
    bandgap_only_a: assert property (pin_ctrl.bandgap_route |-> !pin_ctrl.channel_valid)
        else $error("channel kept with bandgap");
    chan_valid_a: assert property (!pin_ctrl.bandgap_route |-> pin_ctrl.channel_valid
        == (pin_ctrl.channel_route <= 4'hb)) else $error("channel validity wrong");
    power_reset_a: assert property (pin_ctrl.conv_power_off |-> conv_reset)
        else $error("powered off but running");
    held_reset_a: assert property (conv_reset && !pin_ctrl.conv_power_off |-> !conv_sample)
        else $error("sampling while held");
endmodule

bind adc_conversion_control adc_conversion_control_properties chk (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .port_dir_input(port_dir_input),
    .pullup_request(pullup_request), .conv_sample(conv_sample), .conv_reset(conv_reset),
    .pin_ctrl(pin_ctrl));

// file: tb/adc_conversion_control_tb.sv
// Register-level bench for the converter control block
`include "adc_ctrl_map.svh"
module adc_conversion_control_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import adc_ctrl_pkg::*;
    logic        clk_sys, sys_rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
    logic        s_axi_rready, comparator_in, conv_sample, conv_reset, conv_irq;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, v;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, r;
    logic [11:0] port_dir_input, pullup_request, sar_trial_code;
    pin_ctrl_t   pin_ctrl;
    int          miscompares, n_compared, polls;

    adc_conversion_control dut (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .port_dir_input(port_dir_input),
        .pullup_request(pullup_request), .comparator_in(comparator_in),
        .sar_trial_code(sar_trial_code), .conv_sample(conv_sample), .conv_reset(conv_reset),
        .pin_ctrl(pin_ctrl), .conv_irq(conv_irq));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic summarize();
        $display("compared %0d miscompares %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Address and data offered together; each released once taken
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic aw_ok;
        logic w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        @(posedge clk_sys);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= {24'h0, d};
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge clk_sys);
            if (!aw_ok && s_axi_awready === 1'b1) begin
                aw_ok = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (!w_ok && s_axi_wready === 1'b1) begin
                w_ok = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        do @(posedge clk_sys); while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge clk_sys);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge clk_sys); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge clk_sys); while (s_axi_rvalid !== 1'b1);
        v = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
        rd(a);
        check(what, v, exp);
    endtask

    // One start pulse; result is all ones or all zeros with a steady comparator
    task automatic convert(input logic [2:0] sel, input logic al, input logic cmp);
        logic [11:0] res;
        int          d;
        int          cnt;
        res = cmp ? 12'hfff : 12'h000;
        d = (sel == `ADC_DIV_UNDEF) ? 64 : (1 << sel);
        cnt = 0;
        comparator_in <= cmp;
        wr(`ADC_OFS_CTRL_B, {5'h00, sel});
        wr(`ADC_OFS_CTRL_A, {3'h4, al, 4'h0});
        // Held state is entered one edge after the start write lands
        @(posedge clk_sys);
        check("held reset", 32'(conv_reset), 32'h1);
        rdc("busy held", `ADC_OFS_CTRL_A, {24'h0, 3'h6, al, 4'h0});
        wr(`ADC_OFS_CTRL_A, {3'h0, al, 4'h0});
        while (conv_irq !== 1'b1 && cnt < 5000) begin
            @(posedge clk_sys);
            cnt++;
        end
        check("time", 32'(cnt >= 16 * d - 4 && cnt <= 16 * d + 2), 32'h1);
        rdc("busy done", `ADC_OFS_CTRL_A, {24'h0, 3'h0, al, 4'h0});
        rdc("flag", `ADC_OFS_IRQ, 32'h7);
        rdc("res hi", `ADC_OFS_RES_HI, al ? 32'(res[11:8]) : 32'(res[11:4]));
        rdc("res lo", `ADC_OFS_RES_LO, al ? 32'(res[7:0]) : 32'({res[3:0], 4'h0}));
        wr(`ADC_OFS_IRQ, 8'h03);
        check("irq cleared", 32'(conv_irq), 32'h0);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    // Whole run is a few thousand cycles
    initial begin
        #400000;
        miscompares++;
        summarize();
    end

    initial begin
        {sys_rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 5'h10;
        {s_axi_rready, comparator_in, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        s_axi_wstrb = 4'h1;
        port_dir_input = 12'h000;
        pullup_request = 12'h000;
        repeat (3) @(posedge clk_sys);
        sys_rst <= 1'b0;
        rdc("ctrl_a rst", `ADC_OFS_CTRL_A, 32'h20);
        rdc("ctrl_b rst", `ADC_OFS_CTRL_B, 32'h00);
        rdc("pin lo rst", `ADC_OFS_PIN_LO, 32'hff);
        rdc("pin hi rst", `ADC_OFS_PIN_HI, 32'h0f);
        check("trial rst", 32'(sar_trial_code), 32'h800);
        rd(8'h1c);
        check("unmapped", {r, v[29:0]}, 32'h80000000);
        $display("test reset done");
        port_dir_input <= 12'h0a5;
        pullup_request <= 12'hfff;
        wr(`ADC_OFS_PIN_LO, 8'h0f);
        wr(`ADC_OFS_PIN_HI, 8'h08);
        check("pin dir", 32'(pin_ctrl.pin_dir_input), 32'h8af);
        check("pull-high", 32'(pin_ctrl.pin_pullup_on), 32'h7f0);
        wr(`ADC_OFS_CTRL_B, 8'h10);
        check("vref pin", 32'(pin_ctrl.vref_pin_takeover), 32'h1);
        for (int ch = 10; ch < 14; ch++) begin
            wr(`ADC_OFS_CTRL_A, 8'(ch));
            check("chan ok", 32'(pin_ctrl.channel_valid), 32'(ch <= 11));
        end
        wr(`ADC_OFS_CTRL_B, 8'h80);
        check("bandgap", 32'({pin_ctrl.bandgap_route, pin_ctrl.channel_valid}), 32'h2);
        $display("test pins done");
        wr(`ADC_OFS_IRQ, 8'h03);
        for (int s = 0; s < 8; s++) convert(3'(s), s[0], s[1]);
        $display("test conversions done");
        wr(`ADC_OFS_IRQ, 8'h01);
        wr(`ADC_OFS_CTRL_B, 8'h00);
        wr(`ADC_OFS_CTRL_A, 8'h80);
        wr(`ADC_OFS_CTRL_A, 8'h00);
        polls = 0;
        do begin
            rd(`ADC_OFS_CTRL_A);
            polls++;
        end while (v[6] !== 1'b0 && polls < 50);
        check("busy polled", 32'(v[6]), 32'h0);
        check("irq masked", 32'(conv_irq), 32'h0);
        wr(`ADC_OFS_IRQ, 8'h07);
        check("irq unmasked", 32'(conv_irq), 32'h1);
        wr(`ADC_OFS_CTRL_A, 8'h20);
        check("power off", 32'({conv_reset, pin_ctrl.conv_power_off}), 32'h3);
        $display("test polling and power done");
        summarize();
    end
endmodule
